// ===== hdl/exec_core_map.svh
// Register offsets, field positions, reset values and opcodes of the execution block
`ifndef EXEC_CORE_MAP_SVH
`define EXEC_CORE_MAP_SVH
`define REG_CTRL 8'h00
`define REG_WREG 8'h04
`define REG_BANK 8'h08
`define REG_STATUS 8'h0C
`define REG_INDEX_BASE 8'h10
`define REG_WDT_COUNT 8'h14
`define REG_MEM_ADDR 8'h18
`define REG_MEM_DATA 8'h1C
`define CTRL_EXT_EN 0
`define CTRL_WDT_EN 1
`define ST_ZERO 0
`define ST_NEG 1
`define ST_PD_N 2
`define ST_TO_N 3
`define ST_SLEEP 4
`define CTRL_RESET 2'h0
`define OPC_ROTR_MASK 16'hFC00
`define OPC_ROTR_VAL 16'h4000
`define OPC_SET_MASK 16'hFE00
`define OPC_SET_VAL 16'h6800
`define OPC_SLEEP 16'h0003
`define BIT_DEST 9
`define BIT_ACCESS 8
`define ACCESS_LOW_MAX 8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define ONES 8'hFF
`define WDT_POST_DEF 8
`define WDT_LIMIT_DEF 255
`endif

// ===== hdl/exec_core_pkg.sv
// Types shared by the execution block
package exec_core_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DECODE = 3'b001,
    PH_READ = 3'b011,
    PH_PROC = 3'b010,
    PH_WRITE = 3'b110,
    PH_SLEEP = 3'b111
  } phase_e;
  typedef enum logic [1:0] {OP_NONE, OP_ROTR, OP_SET, OP_SLEEP} op_e;
endpackage : exec_core_pkg

// ===== hdl/exec_mem_if.sv
// Data memory connection between the execution core and its memory
`timescale 1ns/10ps
interface exec_mem_if #(parameter int AW = 12) ();
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [AW-1:0] bus_addr;
  logic [7:0] bus_data;
  modport core(output rd_addr, wr_en, wr_addr, wr_data, bus_addr, input rd_data, bus_data);
  modport mem(input rd_addr, wr_en, wr_addr, wr_data, bus_addr, output rd_data, bus_data);
endinterface : exec_mem_if

// ===== hdl/data_store.sv
// Byte-wide data memory with two registered read ports and one write port
`timescale 1ns/10ps
module data_store #(
  parameter int AW = 12
) (
  // Clock
  input wire logic core_clk,
  // Memory side
  exec_mem_if.mem port
);
  logic [7:0] cells [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (port.wr_en) begin
      cells[port.wr_addr] <= port.wr_data;
    end
  end

  // Read data always from a register, never straight from the array
  always_ff @(posedge core_clk) begin
    port.rd_data <= cells[port.rd_addr];
    port.bus_data <= cells[port.bus_addr];
  end
endmodule : data_store

// ===== hdl/phase_tick.sv
// Divider that yields the one-cycle phase enable of the core
`timescale 1ns/10ps
module phase_tick #(
  parameter int DIV = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Enable out
  output logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = (cnt_q >= 16'(DIV - 1));
endmodule : phase_tick

// ===== hdl/rotate_set_sleep_instructions.sv
// Execution of rotate-right, set-to-ones and sleep, with a Wishbone register file
//
// Notes on behaviour
// [RL1] Rotate opcode shifts the file register right one bit, bit 0 into bit 7.
// [RL2] Rotate destination bit 0 writes the working register, 1 writes the file register.
// [RL3] Rotate updates only negative and zero flags, from the rotated result.
// [RL4] Access bit 0 selects the access bank and ignores the bank select register.
// [RL5] Access bit 1 forms the address from bank select register and 8-bit field.
// [RL6] Access bit 0 with extended set on uses indexed offset for field up to 95.
// [RL7] Set opcode writes all ones to the file register, flags untouched.
// [RL8] Sleep opcode halts the core and stops the main oscillator.
// [RL9] Sleep clears the active-low power-down flag.
// [RL10] Sleep sets the active-low time-out flag.
// [RL11] Sleep clears the watchdog counter and its postscaler.
// [RL12] Watchdog expiry that wakes from sleep clears the time-out flag.
// [RL13] Each instruction is one word, one cycle of four phases.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "exec_core_map.svh"
module rotate_set_sleep_instructions #(
  parameter int AW = 12,
  parameter int PHASE_DIV = 1,
  parameter int WDT_POST = `WDT_POST_DEF,
  parameter int WDT_LIMIT = `WDT_LIMIT_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Instruction from the fetch path
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  // Power control
  input wire logic wake_event,
  output logic sleep_active,
  output logic osc_stop,
  output logic wdt_timeout
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic exec_core_pkg::op_e decode_op(input logic [15:0] w);
    if ((w & `OPC_ROTR_MASK) == `OPC_ROTR_VAL) return exec_core_pkg::OP_ROTR;
    if ((w & `OPC_SET_MASK) == `OPC_SET_VAL) return exec_core_pkg::OP_SET;
    if (w == `OPC_SLEEP) return exec_core_pkg::OP_SLEEP;
    return exec_core_pkg::OP_NONE;
  endfunction : decode_op

  function automatic logic [AW-1:0] file_addr(input logic acc, input logic [7:0] f,
      input logic [3:0] bank, input logic ext, input logic [AW-1:0] base);
    if (acc) begin
      return AW'({bank, f}); // [RL5]
    end else if (ext && f <= `ACCESS_LOW_MAX) begin
      return AW'(base + AW'(f)); // [RL6]
    end else if (f <= `ACCESS_LOW_MAX) begin
      return AW'(f); // [RL4]
    end
    return AW'({`ACCESS_HIGH_BANK, f}); // [RL4]
  endfunction : file_addr

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
      input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // State

  exec_mem_if #(.AW(AW)) mem_bus ();
  logic tick;
  exec_core_pkg::phase_e phase_q;
  exec_core_pkg::op_e op_q;
  logic dest_q;
  logic [AW-1:0] addr_q;
  logic [7:0] result_q;
  logic [7:0] wreg_q;
  logic [3:0] bank_q;
  logic [1:0] ctrl_q;
  logic [AW-1:0] base_q;
  logic [AW-1:0] maddr_q;
  logic zero_q;
  logic neg_q;
  logic pd_n_q;
  logic to_n_q;
  logic [15:0] post_q;
  logic [7:0] wdt_q;
  logic wdt_expire;
  logic accept;
  logic core_wr;
  logic core_w_wr;
  logic do_sleep;
  logic bus_req;
  logic bus_mem_wr;
  logic bus_stall;
  logic bus_wr;
  logic [31:0] rd_word;

  phase_tick #(.DIV(PHASE_DIV)) u_tick (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  data_store #(.AW(AW)) u_store (
    .core_clk(core_clk),
    .port(mem_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing

  assign instr_ready = (phase_q == exec_core_pkg::PH_IDLE) && tick;
  assign accept = instr_ready && instr_valid;
  assign do_sleep = tick && phase_q == exec_core_pkg::PH_WRITE &&
                    op_q == exec_core_pkg::OP_SLEEP;
  assign core_wr = tick && phase_q == exec_core_pkg::PH_WRITE && dest_q &&
                   (op_q == exec_core_pkg::OP_ROTR || op_q == exec_core_pkg::OP_SET);
  assign core_w_wr = tick && phase_q == exec_core_pkg::PH_WRITE && !dest_q &&
                     op_q == exec_core_pkg::OP_ROTR; // [RL2]

  // Decode, read, process, write: one phase per enable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= exec_core_pkg::PH_IDLE;
    end else begin
      case (phase_q)
        exec_core_pkg::PH_IDLE: begin
          if (accept) phase_q <= exec_core_pkg::PH_DECODE; // [RL13]
        end
        exec_core_pkg::PH_DECODE: begin
          if (tick) phase_q <= exec_core_pkg::PH_READ;
        end
        exec_core_pkg::PH_READ: begin
          if (tick) phase_q <= exec_core_pkg::PH_PROC;
        end
        exec_core_pkg::PH_PROC: begin
          if (tick) phase_q <= exec_core_pkg::PH_WRITE;
        end
        exec_core_pkg::PH_WRITE: begin
          if (do_sleep) begin
            phase_q <= exec_core_pkg::PH_SLEEP; // [RL8]
          end else if (tick) begin
            phase_q <= exec_core_pkg::PH_IDLE; // [RL13]
          end
        end
        exec_core_pkg::PH_SLEEP: begin
          // Wake runs on the free clock; the phase divider keeps turning meanwhile
          if (wake_event || wdt_expire) phase_q <= exec_core_pkg::PH_IDLE;
        end
        default: begin
          phase_q <= exec_core_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Instruction latch and address formation
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q <= exec_core_pkg::OP_NONE;
      dest_q <= 1'b0;
      addr_q <= '0;
    end else if (accept) begin
      op_q <= decode_op(instr_word);
      // Set always writes the file register
      dest_q <= instr_word[`BIT_DEST] || decode_op(instr_word) == exec_core_pkg::OP_SET;
      addr_q <= file_addr(instr_word[`BIT_ACCESS], instr_word[7:0], bank_q,
                          ctrl_q[`CTRL_EXT_EN], base_q);
    end
  end

  // Memory data is valid by the process phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= 8'h00;
    end else if (tick && phase_q == exec_core_pkg::PH_PROC) begin
      if (op_q == exec_core_pkg::OP_SET) begin
        result_q <= `ONES; // [RL7]
      end else begin
        result_q <= {mem_bus.rd_data[0], mem_bus.rd_data[7:1]}; // [RL1]
      end
    end
  end

  assign mem_bus.rd_addr = addr_q;
  assign mem_bus.bus_addr = maddr_q;
  assign mem_bus.wr_en = core_wr || (bus_mem_wr && wb_sel_i[0]);
  assign mem_bus.wr_addr = core_wr ? addr_q : maddr_q;
  assign mem_bus.wr_data = core_wr ? result_q : wb_dat_i[7:0]; // [RL2]

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (tick && phase_q == exec_core_pkg::PH_WRITE &&
                 op_q == exec_core_pkg::OP_ROTR) begin
      zero_q <= (result_q == 8'h00); // [RL3]
      neg_q <= result_q[7]; // [RL3]
    end else if (bus_wr && wb_adr_i == `REG_STATUS && wb_sel_i[0]) begin
      zero_q <= wb_dat_i[`ST_ZERO];
      neg_q <= wb_dat_i[`ST_NEG];
    end
  end

  // Power-on leaves both active-low flags high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_n_q <= 1'b1;
      to_n_q <= 1'b1;
    end else if (do_sleep) begin
      pd_n_q <= 1'b0; // [RL9]
      to_n_q <= 1'b1; // [RL10]
    end else if (wdt_expire) begin
      to_n_q <= 1'b0; // [RL12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  assign wdt_expire = ctrl_q[`CTRL_WDT_EN] && wdt_q == 8'(WDT_LIMIT) &&
                      post_q == 16'(WDT_POST - 1);
  assign wdt_timeout = wdt_expire && phase_q != exec_core_pkg::PH_SLEEP;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      post_q <= 16'h0000;
      wdt_q <= 8'h00;
    end else if (do_sleep || !ctrl_q[`CTRL_WDT_EN]) begin
      post_q <= 16'h0000; // [RL11]
      wdt_q <= 8'h00; // [RL11]
    end else if (post_q == 16'(WDT_POST - 1)) begin
      post_q <= 16'h0000;
      wdt_q <= wdt_expire ? 8'h00 : wdt_q + 8'h01;
    end else begin
      post_q <= post_q + 16'h0001;
    end
  end

  assign sleep_active = (phase_q == exec_core_pkg::PH_SLEEP); // [RL8]
  assign osc_stop = sleep_active; // [RL8]

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_mem_wr = bus_req && wb_we_i && wb_adr_i == `REG_MEM_DATA && !core_wr;
  // Memory has one write port, so a bus write waits out a core write
  assign bus_stall = wb_we_i && wb_adr_i == `REG_MEM_DATA && core_wr;
  assign bus_wr = bus_req && wb_we_i && !bus_stall;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      `REG_CTRL: rd_word[1:0] = ctrl_q;
      `REG_WREG: rd_word[7:0] = wreg_q;
      `REG_BANK: rd_word[3:0] = bank_q;
      `REG_STATUS: rd_word[4:0] = {sleep_active, to_n_q, pd_n_q, neg_q, zero_q};
      `REG_INDEX_BASE: rd_word[AW-1:0] = base_q;
      `REG_WDT_COUNT: rd_word[7:0] = wdt_q;
      `REG_MEM_ADDR: rd_word[AW-1:0] = maddr_q;
      `REG_MEM_DATA: rd_word[7:0] = mem_bus.bus_data;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !bus_stall;
      if (bus_req && !wb_we_i) wb_dat_o <= rd_word;
    end
  end

  // Core writes to the working register win over a bus write in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wreg_q <= 8'h00;
    end else if (core_w_wr) begin
      wreg_q <= result_q; // [RL2]
    end else if (bus_wr && wb_adr_i == `REG_WREG && wb_sel_i[0]) begin
      wreg_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `CTRL_RESET;
      bank_q <= 4'h0;
      base_q <= '0;
      maddr_q <= '0;
    end else if (bus_wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        `REG_CTRL: ctrl_q <= wb_dat_i[1:0];
        `REG_BANK: bank_q <= wb_dat_i[3:0];
        `REG_INDEX_BASE: base_q <= AW'(merge16(16'(base_q), wb_dat_i, wb_sel_i));
        `REG_MEM_ADDR: maddr_q <= AW'(merge16(16'(maddr_q), wb_dat_i, wb_sel_i));
        default: begin
        end
      endcase
    end
  end
endmodule : rotate_set_sleep_instructions

// ===== testbench/rss_props.sv
// Port-level assertions for the execution block
`timescale 1ns/10ps
module rss_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Instructions and power
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic wake_event,
  input wire logic sleep_active,
  input wire logic osc_stop,
  input wire logic wdt_timeout
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = instr_valid && instr_ready;
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("bus request left without ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_busy_phases: assert property (take |=> !instr_ready [*4])
    else $error("core took a word during its phases");
  a_one_cycle: assert property (take && instr_word != 16'h0003 |-> ##5 instr_ready)
    else $error("instruction cycle not four phases");
  a_sleep_entry: assert property (take && instr_word == 16'h0003 |-> ##4 !sleep_active ##1 sleep_active)
    else $error("sleep not entered at write phase");
  a_osc_stop: assert property (osc_stop == sleep_active)
    else $error("oscillator stop differs from sleep");
  a_asleep_halt: assert property (sleep_active |-> !instr_ready)
    else $error("core ready while asleep");
  a_wake_exit: assert property (sleep_active && wake_event |=> !sleep_active)
    else $error("wake did not leave sleep");
  a_wdt_awake: assert property (wdt_timeout |-> !sleep_active && !$past(wdt_timeout))
    else $error("watchdog pulse while asleep or held");
endmodule : rss_props
bind rotate_set_sleep_instructions rss_props u_props (.core_clk(core_clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .wake_event(wake_event),
  .sleep_active(sleep_active), .osc_stop(osc_stop), .wdt_timeout(wdt_timeout));

// ===== testbench/fetch_model.sv
// Instruction fetch model that offers one word and holds it until taken
`timescale 1ns/10ps
module fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bench side
  input wire logic send,
  input wire logic [15:0] word_in,
  output logic taken,
  // Core side
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
      taken <= 1'b0;
    end else begin
      taken <= instr_valid && instr_ready;
      if (instr_valid && instr_ready) begin
        instr_valid <= 1'b0;
      end
      if (!instr_valid && send) begin
        instr_valid <= 1'b1;
        instr_word <= word_in;
      end else if (!instr_valid || instr_ready) begin
        // Unoffered word toggles so a stale value never looks valid
        instr_word <= ~instr_word;
      end
    end
  end
endmodule : fetch_model

// ===== testbench/rotate_set_sleep_instructions_bench.sv
// Self-checking bench for the execution block
`timescale 1ns/10ps
`include "exec_core_map.svh"
module rotate_set_sleep_instructions_bench;
  logic core_clk = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wake_event = 0;
  logic send = 0, wb_ack_o, instr_ready, instr_valid, sleep_active, osc_stop, taken;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic [15:0] word_in = 16'h0000, rnd = 16'h9CC6, instr_word;
  logic [31:0] exp_q[$];
  int num_errors = 0, cmp_count = 0;
  rotate_set_sleep_instructions #(.WDT_POST(4), .WDT_LIMIT(15)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .wake_event(wake_event), .sleep_active(sleep_active),
    .osc_stop(osc_stop), .wdt_timeout());
  fetch_model fetch (.core_clk(core_clk), .arst_n(arst_n), .send(send), .word_in(word_in),
    .taken(taken), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict(input bit hung);
    if (hung) num_errors++;
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  function automatic logic [7:0] nxt();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd[7:0];
  endfunction : nxt
  // Reads note their expected word; the monitor compares it at the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!we) exp_q.push_back(d);
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) begin
      if (++k > 50) print_verdict(1);
      @(posedge core_clk);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : wb
  task automatic exec(input logic [15:0] w, input int n);
    int k;
    k = 0;
    word_in <= w;
    send <= 1'b1;
    @(posedge core_clk);
    send <= 1'b0;
    while (taken !== 1'b1) begin
      if (++k > 50) print_verdict(1);
      @(posedge core_clk);
    end
    repeat (n) @(posedge core_clk);
  endtask : exec
  task automatic wait_sleep(input logic v);
    int k;
    k = 0;
    while (sleep_active !== v) begin
      if (++k > 200) print_verdict(1);
      @(posedge core_clk);
    end
  endtask : wait_sleep
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) cmp(wb_dat_o, exp_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, f, r, b;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    wb(0, `REG_STATUS, 32'h0000_000C);
    wb(1, 8'h40, 32'h0000_00FF);
    wb(0, 8'h40, 32'h0000_0000);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      b = nxt();
      f = (i < 4) ? nxt() % 8'h60 : nxt();
      d = (i == 5) ? 8'h00 : nxt();
      r = {d[0], d[7:1]};
      wb(1, `REG_BANK, {28'h0, b[3:0]});
      wb(1, `REG_MEM_ADDR, (i < 4) ? {24'h0, f} : {20'h0, b[3:0], f});
      wb(1, `REG_MEM_DATA, {24'h0, d});
      exec((i < 4) ? 16'h4200 | {8'h00, f} : 16'h4100 | {8'h00, f}, 5);
      if (i < 4) wb(0, `REG_MEM_DATA, {24'h0, r});
      else wb(0, `REG_WREG, {24'h0, r});
      wb(0, `REG_STATUS, {28'h0, 2'b11, r[7], r == 8'h00});
    end
    $display("test rotate done");
    wb(1, `REG_CTRL, 32'h0000_0001);
    wb(1, `REG_INDEX_BASE, 32'h0000_0100);
    for (int i = 0; i < 2; i++) begin
      wb(1, `REG_MEM_ADDR, i ? 32'h0000_0F80 : 32'h0000_015F);
      wb(1, `REG_MEM_DATA, 32'h0000_0000);
      exec(i ? 16'h6880 : 16'h685F, 5);
      wb(0, `REG_MEM_DATA, 32'h0000_00FF);
    end
    wb(0, `REG_STATUS, 32'h0000_000D);
    $display("test set done");
    wb(1, `REG_CTRL, 32'h0000_0002);
    repeat (40) @(posedge core_clk);
    exec(`OPC_SLEEP, 0);
    wait_sleep(1'b1);
    wb(0, `REG_WDT_COUNT, 32'h0000_0000);
    wb(0, `REG_STATUS, 32'h0000_0019);
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    wait_sleep(1'b0);
    exec(`OPC_SLEEP, 0);
    wait_sleep(1'b1);
    wait_sleep(1'b0);
    wb(0, `REG_STATUS, 32'h0000_0001);
    $display("test sleep done");
    print_verdict(0);
  end
endmodule : rotate_set_sleep_instructions_bench
